// [bench/pin_model.sv]
// far-side model: timer input pin and comparator output
`timescale 1ns/10ps
`default_nettype none
module pin_model (
   input wire logic core_clk,
   output logic timerIn,
   output logic compOut
);
   initial begin
      timerIn = 1'b0;
      compOut = 1'b0;
   end
   task automatic drive(input logic useComp, input logic lvl);
      repeat (4) @(posedge core_clk);
      if (useComp) compOut <= lvl;
      else timerIn <= lvl;
   endtask : drive
   task automatic pulses(input logic useComp, input int n);
      for (int i = 0; i < n; i++) begin
         if (i > 0) drive(useComp, 1'b0);
         drive(useComp, 1'b1);
      end
   endtask : pulses
endmodule : pin_model
`default_nettype wire

// [bench/test_timer_counting_modes.sv]
// self-checking bench for the timer block
`timescale 1ns/10ps
`default_nettype none
module test_timer_counting_modes
   import timer_pkg::*;
;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire timerIn;
   wire compOut;
   wire timerOut;
   wire irq;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   logic [32:0] expQ[$];

   timer_counting_modes dut (.core_clk(core_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timerIn(timerIn), .compOut(compOut),
      .timerOut(timerOut), .irq(irq));
   pin_model pin (.core_clk(core_clk), .timerIn(timerIn), .compOut(compOut));

   always #20 core_clk = ~core_clk;

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         end_of_test();
      end
   end

   // read results against the oldest note
   always @(posedge core_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, expQ.pop_front());
   end

   task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, d, 1'b1);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      expQ.push_back({err, e});
      xfer(a, 32'h0, 1'b0);
   endtask : rd

   function automatic ctrl_t mk(mode_t m, logic [2:0] pre, logic pol, logic oe, logic en);
      mk = '{outEn: oe, outputPolarityBit: pol, prescale: pre, mode: m, en: en};
   endfunction : mk

   task automatic cfg(input mode_t m, input logic [2:0] pre, input logic pol, oe, en);
      wr(OFF_CTRL, {24'h0, mk(m, pre, pol, oe, en)});
   endtask : cfg

   task automatic waitToggle(output int n);
      logic last;
      last = timerOut;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (timerOut === last && n < 100);
   endtask : waitToggle

   initial begin
      int k;
      int n;
      logic [31:0] v;
      void'($urandom(32'h845548e7));
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      rd(OFF_CTRL, {24'h0, CTRL_RESET}, 1'b0);
      rd(OFF_COUNT, {16'h0, COUNT_RESET}, 1'b0);
      rd(OFF_RELOAD, {16'h0, RELOAD_RESET}, 1'b0);
      rd(OFF_STATUS, {31'h0, STATUS_RESET}, 1'b0);
      rd(OFF_MASK, {31'h0, MASK_RESET}, 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      v = $urandom;
      wr(OFF_COUNT, v);
      repeat (5) @(posedge core_clk);
      rd(OFF_COUNT, {16'h0, v[15:0]}, 1'b0);
      rd(OFF_STATUS, 32'h0, 1'b0);
      // one-shot, divide by two, 3 up to 8
      // configure disabled first
      cfg(MODE_ONESHOT, 3'h1, 1'b0, 1'b0, 1'b0);
      wr(OFF_MASK, 32'h1);
      wr(OFF_COUNT, 32'h3);
      wr(OFF_RELOAD, 32'h8);
      cfg(MODE_ONESHOT, 3'h1, 1'b0, 1'b0, 1'b1);
      repeat (11) @(posedge core_clk);
      #1 check({32'h0, irq}, 33'h0);
      @(posedge core_clk);
      #1 check({32'h0, irq}, 33'h1);
      rd(OFF_COUNT, 32'h1, 1'b0);
      rd(OFF_CTRL, {24'h0, mk(MODE_ONESHOT, 3'h1, 1'b0, 1'b0, 1'b0)}, 1'b0);
      wr(OFF_STATUS, 32'h1);
      rd(OFF_STATUS, 32'h0, 1'b0);
      #1 check({32'h0, irq}, 33'h0);
      // continuous, 1 up to 4, pin toggling, masked
      // configure disabled first
      cfg(MODE_CONTINUOUS, 3'h0, 1'b0, 1'b1, 1'b0);
      wr(OFF_MASK, 32'h0);
      wr(OFF_COUNT, 32'h1);
      wr(OFF_RELOAD, 32'h4);
      cfg(MODE_CONTINUOUS, 3'h0, 1'b0, 1'b1, 1'b1);
      waitToggle(n);
      waitToggle(n);
      check(33'(n), 33'h4);
      rd(OFF_STATUS, 32'h1, 1'b0);
      #1 check({32'h0, irq}, 33'h0);
      wr(OFF_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      #1 check({32'h0, irq}, 33'h1);
      cfg(MODE_CONTINUOUS, 3'h0, 1'b0, 1'b1, 1'b0);
      // one-shot level change: polarity flipped after start
      cfg(MODE_ONESHOT, 3'h0, 1'b0, 1'b1, 1'b0);
      wr(OFF_COUNT, 32'h1);
      wr(OFF_RELOAD, 32'h8);
      cfg(MODE_ONESHOT, 3'h0, 1'b0, 1'b1, 1'b1);
      cfg(MODE_ONESHOT, 3'h0, 1'b1, 1'b1, 1'b1);
      #1 check({32'h0, timerOut}, 33'h0);
      repeat (8) @(posedge core_clk);
      #1 check({32'h0, timerOut}, 33'h1);
      rd(OFF_CTRL, {24'h0, mk(MODE_ONESHOT, 3'h0, 1'b1, 1'b1, 1'b0)}, 1'b0);
      // edge counting in both modes and polarities, reload 4 wraps
      for (int m = 2; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            k = 2 + $urandom % 6;
            // configure disabled, start count, enable last
            cfg(mode_t'(m), 3'h7, p[0], 1'b1, 1'b0);
            wr(OFF_COUNT, 32'h1);
            wr(OFF_RELOAD, 32'h4);
            #1 check({32'h0, timerOut}, {32'h0, p[0]});
            cfg(mode_t'(m), 3'h7, p[0], 1'b1, 1'b1);
            pin.pulses(m == 3, k);
            repeat (4) @(posedge core_clk);
            n = 1 + (k - p) % 3;
            rd(OFF_COUNT, 32'(n), 1'b0);
            #1 check({32'h0, timerOut}, {32'h0, p[0] ^ 1'(((k - p) / 3) % 2)});
            cfg(mode_t'(m), 3'h7, p[0], 1'b0, 1'b0);
            pin.drive(m == 3, 1'b0);
         end
      end
      end_of_test();
   end
endmodule : test_timer_counting_modes
`default_nettype wire

// [logic/edge_sync.sv]
// two-flop synchroniser with a selectable edge detector
`timescale 1ns/10ps
`default_nettype none
module edge_sync (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic din,
   input wire logic fallSel,
   output logic edgePulse
);
   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
      end else begin
         stage1_reg <= din;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // only the settled stages feed the detector
   assign edgePulse = fallSel ? (stage3_reg & ~stage2_reg) : (~stage3_reg & stage2_reg);
endmodule : edge_sync
`default_nettype wire

// [logic/timer_counting_modes.sv]
// 16-bit timer with one-shot, continuous, counter and comparator modes, APB slave
// Notes on behaviour
// - one-shot counts prescaled clock, never pins
// - one-shot ends after (reload-start)*2^prescale clocks
// - continuous counts up until count equals reload
// - continuous counts the prescaled system clock
// - continuous reload: interrupt, count 0001, keep going
// - output pin toggles on reload when enabled
// - counter mode edge chosen by polarity bit
// - after reload counter restarts from 0001
// - one increment per qualifying input edge
// - comparator mode counts comparator output transitions
// - polarity bit picks comparator edge
// - comparator mode bypasses the prescaler
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module timer_counting_modes
   import timer_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timerIn,
   input wire logic compOut,
   output logic timerOut,
   output logic irq
);
   ctrl_t ctrl_reg;
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] reload_reg;
   logic [EVT_W-1:0] status_reg;
   logic [EVT_W-1:0] status_next;
   logic [EVT_W-1:0] mask_reg;
   logic [PRE_W-1:0] preCnt_reg;
   logic [PRE_W-1:0] preLimit;
   logic level_reg;
   logic level_next;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic timerOut_reg;
   logic irq_reg;

   logic setupPhase;
   logic accessDone;
   logic wrCtrl;
   logic wrCount;
   logic wrReload;
   logic wrStatus;
   logic wrMask;
   logic mapped;
   logic [31:0] readMux;
   logic preTick;
   logic inEdge;
   logic compEdge;
   logic countTick;
   logic reloadHit;

   // apb decode
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready_reg;
   assign wrCtrl = accessDone & pwrite & (paddr == OFF_CTRL);
   assign wrCount = accessDone & pwrite & (paddr == OFF_COUNT);
   assign wrReload = accessDone & pwrite & (paddr == OFF_RELOAD);
   assign wrStatus = accessDone & pwrite & (paddr == OFF_STATUS);
   assign wrMask = accessDone & pwrite & (paddr == OFF_MASK);

   always_comb begin
      mapped = 1'b1;
      readMux = 32'h0000_0000;
      unique case (paddr)
         OFF_CTRL: readMux = {24'h00_0000, ctrl_reg};
         OFF_COUNT: readMux = {16'h0000, count_reg};
         OFF_RELOAD: readMux = {16'h0000, reload_reg};
         OFF_STATUS: readMux = {31'h0000_0000, status_reg};
         OFF_MASK: readMux = {31'h0000_0000, mask_reg};
         default: mapped = 1'b0;
      endcase
   end

   // one access cycle: ready is raised from the setup cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setupPhase;
         pslverr_reg <= setupPhase & ~mapped;
         if (setupPhase && !pwrite) begin
            prdata_reg <= readMux;
         end else if (accessDone) begin
            prdata_reg <= 32'h0000_0000;
         end
      end
   end

   // synchronised pin and comparator edges
   // edge selected by polarity
   edge_sync u_inSync (
      .core_clk(core_clk),
      .resetn(resetn),
      .din(timerIn),
      .fallSel(ctrl_reg.outputPolarityBit),
      .edgePulse(inEdge)
   );

   edge_sync u_compSync (
      .core_clk(core_clk),
      .resetn(resetn),
      .din(compOut),
      .fallSel(ctrl_reg.outputPolarityBit),
      .edgePulse(compEdge)
   );

   // period scales with prescale
   // prescaler divides by 2 to the power of the prescale field
   assign preLimit = PRE_W'((8'h01 << ctrl_reg.prescale) - 8'h01);
   assign preTick = (preCnt_reg == preLimit);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         preCnt_reg <= PRE_RESET;
      end else if (!ctrl_reg.en || preTick) begin
         preCnt_reg <= PRE_RESET;
      end else begin
         preCnt_reg <= preCnt_reg + 7'h01;
      end
   end

   // count source per mode
   always_comb begin
      countTick = 1'b0;
      unique case (ctrl_reg.mode)
         MODE_ONESHOT, MODE_CONTINUOUS: countTick = ctrl_reg.en & preTick;
         MODE_COUNTER: countTick = ctrl_reg.en & inEdge;
         MODE_COMPARATOR: countTick = ctrl_reg.en & compEdge;
      endcase
   end

   assign reloadHit = ctrl_reg.en & (count_reg == reload_reg);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= COUNT_RESET;
      end else if (reloadHit) begin
         count_reg <= COUNT_RESTART;
      end else if (wrCount) begin
         count_reg <= pwdata[15:0];
      end else if (countTick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reload_reg <= RELOAD_RESET;
      end else if (wrReload) begin
         reload_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_reg <= ctrl_t'(pwdata[7:0]);
      end else if (reloadHit && ctrl_reg.mode == MODE_ONESHOT) begin
         ctrl_reg.en <= 1'b0;
      end
   end

   // sticky status, set wins over write-one-to-clear
   always_comb begin
      status_next = status_reg;
      if (wrStatus) begin
         status_next = status_reg & ~pwdata[EVT_W-1:0];
      end
      status_next[STATUS_RELOAD_BIT] = status_next[STATUS_RELOAD_BIT] | reloadHit;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status_reg <= STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mask_reg <= MASK_RESET;
      end else if (wrMask) begin
         mask_reg <= pwdata[EVT_W-1:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   // idle level follows polarity, reload toggles
   always_comb begin
      level_next = level_reg;
      if (!ctrl_reg.en) begin
         level_next = ctrl_reg.outputPolarityBit;
      end else if (reloadHit) begin
         level_next = ~level_reg;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         level_reg <= 1'b0;
         timerOut_reg <= 1'b0;
      end else begin
         level_reg <= level_next;
         timerOut_reg <= ctrl_reg.outEn & level_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign timerOut = timerOut_reg;
   assign irq = irq_reg;

   // checking helpers: cycles since enable and start value
   logic enPrev_reg;
   logic runDirty_reg;
   logic [23:0] runCycles_reg;
   logic [COUNT_W-1:0] startVal_reg;
   logic [23:0] expectCycles;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         enPrev_reg <= 1'b0;
         runDirty_reg <= 1'b0;
         runCycles_reg <= 24'h00_0000;
         startVal_reg <= COUNT_RESET;
      end else begin
         enPrev_reg <= ctrl_reg.en;
         if (ctrl_reg.en && !enPrev_reg) begin
            runCycles_reg <= 24'h00_0001;
            startVal_reg <= count_reg;
            runDirty_reg <= wrCount | wrCtrl;
         end else begin
            runCycles_reg <= runCycles_reg + 24'h00_0001;
            runDirty_reg <= runDirty_reg | wrCount | wrCtrl;
         end
      end
   end

   assign expectCycles = 24'((reload_reg - startVal_reg) * (17'h0_0001 << ctrl_reg.prescale));

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   oneshot_source_a: assert property (
      ctrl_reg.en && ctrl_reg.mode == MODE_ONESHOT && !preTick && !reloadHit && !wrCount
      |=> $stable(count_reg))
      else $error("one-shot count moved without a prescaler tick");

   oneshot_period_a: assert property (
      reloadHit && ctrl_reg.mode == MODE_ONESHOT && enPrev_reg && !runDirty_reg
      && reload_reg > startVal_reg
      |-> runCycles_reg == expectCycles)
      else $error("one-shot time-out at wrong cycle");

   cont_reload_a: assert property (
      reloadHit && ctrl_reg.mode == MODE_CONTINUOUS && !wrCtrl
      |=> count_reg == COUNT_RESTART && ctrl_reg.en && status_reg[STATUS_RELOAD_BIT])
      else $error("continuous reload did not restart and flag");

   out_toggle_a: assert property (
      reloadHit && ctrl_reg.outEn && ctrl_reg.mode != MODE_ONESHOT && !wrCtrl
      |=> timerOut_reg != $past(timerOut_reg))
      else $error("output pin did not toggle on reload");

   edge_count_a: assert property (
      ctrl_reg.en && ctrl_reg.mode == MODE_COUNTER && !reloadHit && !wrCount
      |=> count_reg == $past(count_reg) + {15'h0000, $past(inEdge)})
      else $error("counter mode count differs from edge count");

   comp_count_a: assert property (
      ctrl_reg.en && ctrl_reg.mode == MODE_COMPARATOR && compEdge && !reloadHit && !wrCount
      |=> count_reg == $past(count_reg) + 16'h0001)
      else $error("comparator edge did not advance count");

   oneshot_stop_a: assert property (
      reloadHit && ctrl_reg.mode == MODE_ONESHOT && !wrCtrl
      |=> !ctrl_reg.en && count_reg == COUNT_RESTART ##1 (!ctrl_reg.en || $past(wrCtrl)))
      else $error("one-shot did not stop at reload");

   idle_hold_a: assert property (
      !ctrl_reg.en && !wrCount && !wrCtrl
      |=> $stable(count_reg) && !reloadHit)
      else $error("disabled timer changed count");

   irq_level_a: assert property (
      |(status_reg & mask_reg) |=> irq_reg)
      else $error("unmasked status did not raise interrupt");

   cont_reload_c: cover property (reloadHit && ctrl_reg.mode == MODE_CONTINUOUS);
   oneshot_done_c: cover property (reloadHit && ctrl_reg.mode == MODE_ONESHOT);
   counter_reload_c: cover property (reloadHit && ctrl_reg.mode == MODE_COUNTER);
   comp_edge_c: cover property (countTick && ctrl_reg.mode == MODE_COMPARATOR);
endmodule : timer_counting_modes
`default_nettype wire

// [logic/timer_pkg.sv]
// constants, field layout and types shared by the timer block
package timer_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_RELOAD = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_MASK = 8'h10;
   // control and status field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_PRE_LSB = 3;
   localparam int CTRL_POL_BIT = 6;
   localparam int CTRL_OUTEN_BIT = 7;
   localparam int STATUS_RELOAD_BIT = 0;
   // widths
   localparam int COUNT_W = 16;
   localparam int PRE_W = 7;
   localparam int EVT_W = 1;
   // reset and restart values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] RELOAD_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESTART = 16'h0001;
   localparam logic [0:0] STATUS_RESET = 1'h0;
   localparam logic [0:0] MASK_RESET = 1'h0;
   localparam logic [PRE_W-1:0] PRE_RESET = 7'h00;

   typedef enum logic [1:0] {
      MODE_ONESHOT = 2'h0,
      MODE_CONTINUOUS = 2'h1,
      MODE_COUNTER = 2'h2,
      MODE_COMPARATOR = 2'h3
   } mode_t;

   // control register layout, msb first
   typedef struct packed {
      logic outEn;
      logic outputPolarityBit;
      logic [2:0] prescale;
      mode_t mode;
      logic en;
   } ctrl_t;
endpackage : timer_pkg
